// ==== rtl/flash_pkg.sv ====
// shared constants and types for the serial flash command logic
`default_nettype none
package flash_pkg;
	localparam int CLK_FREQ_MHZ = 25;
	// self-timed cycle lengths in microseconds
	localparam int STATUS_WRITE_TIME_US = 5000;
	localparam int SMALL_WIPE_TIME_US   = 60000;
	localparam int BLOCK_WIPE_TIME_US   = 700000;
	localparam int ARRAY_WIPE_TIME_US   = 2000000;
	localparam int STATUS_WRITE_CYC = STATUS_WRITE_TIME_US * CLK_FREQ_MHZ;
	localparam int SMALL_WIPE_CYC   = SMALL_WIPE_TIME_US * CLK_FREQ_MHZ;
	localparam int BLOCK_WIPE_CYC   = BLOCK_WIPE_TIME_US * CLK_FREQ_MHZ;
	localparam int ARRAY_WIPE_CYC   = ARRAY_WIPE_TIME_US * CLK_FREQ_MHZ;
	// instruction codes
	localparam logic [7:0] OPC_WRITE_UNLOCK = 8'h06;
	localparam logic [7:0] OPC_WRITE_LOCK   = 8'h04;
	localparam logic [7:0] OPC_STATUS_READ  = 8'h05;
	localparam logic [7:0] OPC_STATUS_WRITE = 8'h01;
	localparam logic [7:0] OPC_READ         = 8'h03;
	localparam logic [7:0] OPC_FAST_READ    = 8'h0B;
	localparam logic [7:0] OPC_DUAL_READ    = 8'h3B;
	localparam logic [7:0] OPC_SMALL_WIPE   = 8'h20;
	localparam logic [7:0] OPC_BLOCK_WIPE_A = 8'h52;
	localparam logic [7:0] OPC_BLOCK_WIPE_B = 8'hD8;
	localparam logic [7:0] OPC_ARRAY_WIPE_A = 8'h60;
	localparam logic [7:0] OPC_ARRAY_WIPE_B = 8'hC7;
	// status word layout
	localparam int BUSY_BIT     = 0;
	localparam int LATCH_BIT    = 1;
	localparam int GUARD_LO_BIT = 2;
	localparam int GUARD_HI_BIT = 3;
	localparam int LOCK_BIT     = 7;
	localparam logic       LOCK_RESET  = 1'b0;
	localparam logic [1:0] GUARD_RESET = 2'h0;
	// frame lengths counted in serial-clock edges, field lengths counted in bits
	localparam logic [5:0] OP_EDGES   = 6'h08;
	localparam logic [5:0] WSR_EDGES  = 6'h10;
	localparam logic [5:0] WIPE_EDGES = 6'h20;
	localparam logic [5:0] EDGE_MAX   = 6'h3F;
	localparam logic [4:0] ADDR_BITS  = 5'h18;
	localparam logic [4:0] DUMMY_BITS = 5'h08;
	localparam logic [4:0] BYTE_BITS  = 5'h08;
	localparam int SECTOR_LSB = 12;
	localparam int BLOCK_LSB  = 16;
	// synchroniser lanes and their idle levels
	localparam int PIN_CS   = 0;
	localparam int PIN_SCLK = 1;
	localparam int PIN_DQ0  = 2;
	localparam int PIN_DQ1  = 3;
	localparam int PIN_WP   = 4;
	localparam logic [4:0] PIN_IDLE = 5'h11;
	typedef enum {PH_OP, PH_ADDR, PH_DUMMY, PH_DATA, PH_WSR, PH_HOLD} phase_t;
endpackage
`default_nettype wire

// ==== rtl/pin_evt_if.sv ====
// synchronised pin levels and serial-clock events
`default_nettype none
interface pin_evt_if;
	logic sclk_rise;
	logic sclk_fall;
	logic cs_active;
	logic cs_start;
	logic cs_end;
	logic dq0;
	logic dq1;
	logic wp_n;
	modport src (output sclk_rise, sclk_fall, cs_active, cs_start, cs_end,
		dq0, dq1, wp_n);
	modport dst (input sclk_rise, sclk_fall, cs_active, cs_start, cs_end,
		dq0, dq1, wp_n);
endinterface
`default_nettype wire

// ==== rtl/pin_sync.sv ====
// three-stage pin synchroniser with edge detection
`default_nettype none
module pin_sync
	import flash_pkg::*;
(
	input  wire logic clk,
	input  wire logic sys_rst,
	input  wire logic cs_n,
	input  wire logic sclk,
	input  wire logic dq0_in,
	input  wire logic dq1_in,
	input  wire logic wp_n,
	pin_evt_if.src    evt
);
	logic [4:0] s1, s2, s3, stable;
	wire  [4:0] raw = {wp_n, dq1_in, dq0_in, sclk, cs_n};
	// a lane moves only once the second and third stages agree
	wire  [4:0] differ = s2 ^ s3;
	wire  [4:0] next_stable = (s3 & ~differ) | (stable & differ);

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			s1 <= PIN_IDLE;
			s2 <= PIN_IDLE;
			s3 <= PIN_IDLE;
			stable <= PIN_IDLE;
		end else begin
			s1 <= raw;
			s2 <= s1;
			s3 <= s2;
			stable <= next_stable;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			evt.sclk_rise <= 1'b0;
			evt.sclk_fall <= 1'b0;
			evt.cs_active <= 1'b0;
			evt.cs_start  <= 1'b0;
			evt.cs_end    <= 1'b0;
			evt.dq0       <= 1'b0;
			evt.dq1       <= 1'b0;
			evt.wp_n      <= 1'b1;
		end else begin
			evt.sclk_rise <= next_stable[PIN_SCLK] & ~stable[PIN_SCLK];
			evt.sclk_fall <= ~next_stable[PIN_SCLK] & stable[PIN_SCLK];
			evt.cs_active <= ~next_stable[PIN_CS];
			evt.cs_start  <= ~next_stable[PIN_CS] & stable[PIN_CS];
			evt.cs_end    <= next_stable[PIN_CS] & ~stable[PIN_CS];
			evt.dq0       <= next_stable[PIN_DQ0];
			evt.dq1       <= next_stable[PIN_DQ1];
			evt.wp_n      <= next_stable[PIN_WP];
		end
	end
endmodule // pin_sync
`default_nettype wire

// ==== rtl/flash_core.sv ====
// serial flash command logic: status write, guard modes, reads and erase
//
// Behaviour
// R1 - status write needs the write latch set; refused when latch clear
// R2 - status write changes only the two guard bits and the lock bit
// R3 - status write executes only if chip select rises after exactly 16 bits
// R4 - status write runs self-timed with busy set, then clears busy and latch
// R5 - lock set and protect pin low: pin-guard mode, status writes refused
// R6 - otherwise soft-guard mode, latch-enabled status writes accepted
// R7 - pin-guard entered by lock or pin in any order, left by pin high
// R8 - both guard modes refuse erase of the guarded region
// R9 - normal read samples on rising, drives on falling serial-clock edges
// R10 - reads start anywhere, address increments per byte, wraps to zero
// R11 - fast read ignored while busy, else like normal read
// R12 - dual read moves address, dummy and data two bits per edge
// R13 - dual read rejected while busy, running cycle untouched
// R14 - two-bit transfers only for the array read
// R15 - sector erase needs latch, any address in sector, sets sector to ones
// R16 - sector erase only on exact frame end; busy, then busy and latch clear
// R17 - sector erase refused on a guarded area
// R18 - block erase needs latch and exact frame end; busy then clears
// R19 - block erase refused on a guarded area
// R20 - array erase needs latch and exact frame end; busy then clears
// R21 - array erase only when both guard bits are zero
// R22 - status layout: busy bit 0, latch bit 1, guard bits 2-3, lock bit 7
// R23 - latch clears at reset and on completion of lock and write cycles
// R24 - write-type instructions ignored while busy, latch unaffected
// R25 - erase or status write with clear latch at frame end is ignored
`default_nettype none
module flash_core
	import flash_pkg::*;
#(
	parameter int ADDR_W           = 18,
	parameter int STATUS_WRITE_CYC = flash_pkg::STATUS_WRITE_CYC,
	parameter int SMALL_WIPE_CYC   = flash_pkg::SMALL_WIPE_CYC,
	parameter int BLOCK_WIPE_CYC   = flash_pkg::BLOCK_WIPE_CYC,
	parameter int ARRAY_WIPE_CYC   = flash_pkg::ARRAY_WIPE_CYC
) (
	input  wire logic clk,
	input  wire logic sys_rst,
	input  wire logic cs_n,
	input  wire logic sclk,
	input  wire logic dq0_in,
	input  wire logic dq1_in,
	input  wire logic wp_n,
	output var  logic dq0_out,
	output var  logic dq0_oe,
	output var  logic dq1_out,
	output var  logic dq1_oe,
	output var  logic busy_flag,
	output var  logic write_latch,
	output var  logic region_guard_hi,
	output var  logic region_guard_lo,
	output var  logic status_lock_bit,
	output var  logic pin_guard_mode,
	output var  logic soft_guard_mode
);
	import flash_pkg::*;

	// below 64 KiB the block span saturates to the whole array
	if (ADDR_W <= SECTOR_LSB || ADDR_W > 24) begin : g_chk
		$error("ADDR_W must lie in 13..24");
	end
	if (STATUS_WRITE_CYC < 1 || SMALL_WIPE_CYC < 1 || BLOCK_WIPE_CYC < 1 ||
		ARRAY_WIPE_CYC < 1) begin : g_chk_cyc
		$error("cycle counts must be at least one");
	end

	localparam int MEM_BYTES = 1 << ADDR_W;
	typedef logic [ADDR_W-1:0] addr_t;

	function automatic addr_t align_down(addr_t a, int lsb);
		align_down = a & ~((addr_t'(1) << lsb) - addr_t'(1));
	endfunction

	// guarded area is the top quarter, half or whole array
	function automatic logic is_guarded(logic [1:0] g, addr_t hi);
		logic [ADDR_W:0] size;
		size = (ADDR_W+1)'(MEM_BYTES) >> (2'h3 - g);
		is_guarded = (g != 2'h0) &&
			({1'b0, hi} >= (ADDR_W+1)'(MEM_BYTES) - size);
	endfunction

	pin_evt_if evt ();

	pin_sync u_sync (
		.clk     (clk),
		.sys_rst (sys_rst),
		.cs_n    (cs_n),
		.sclk    (sclk),
		.dq0_in  (dq0_in),
		.dq1_in  (dq1_in),
		.wp_n    (wp_n),
		.evt     (evt)
	);

	logic [7:0]  mem [0:MEM_BYTES-1];
	phase_t      phase;
	logic [7:0]  opcode;
	logic [7:0]  shin;
	logic [23:0] addr_acc;
	logic [5:0]  edges;
	logic [4:0]  cnt;
	logic        dual;
	logic        stat_rd;
	addr_t       rd_addr;
	logic [7:0]  obuf;
	logic [2:0]  ocnt;
	logic [31:0] timer;
	logic        wiping;
	addr_t       wipe_ptr;
	addr_t       wipe_end;

	// decode and selection
	wire  [4:0]  step      = (dual && phase != PH_OP) ? 5'h02 : 5'h01;
	wire  [4:0]  cnt_next  = cnt + step;
	wire  [7:0]  op_next   = {shin[6:0], evt.dq0};
	wire  [23:0] addr_next = dual ? {addr_acc[21:0], evt.dq1, evt.dq0}
		: {addr_acc[22:0], evt.dq0};
	wire         addr_done = cnt_next == ADDR_BITS;
	wire  [1:0]  guard     = {region_guard_hi, region_guard_lo};
	wire         pin_guard = status_lock_bit & ~evt.wp_n; // see R5 see R7
	wire         wr_ok     = write_latch & ~busy_flag; // see R1 see R24 see R25
	wire  addr_t frame_addr = addr_acc[ADDR_W-1:0];
	wire  addr_t sec_lo    = align_down(frame_addr, SECTOR_LSB);
	wire  addr_t blk_lo    = align_down(frame_addr, BLOCK_LSB);
	wire  addr_t sec_hi    = sec_lo | ((addr_t'(1) << SECTOR_LSB) - addr_t'(1));
	wire  addr_t blk_hi    = blk_lo | ((addr_t'(1) << BLOCK_LSB) - addr_t'(1));
	wire         is_blk    = opcode == OPC_BLOCK_WIPE_A ||
		opcode == OPC_BLOCK_WIPE_B;
	wire         is_arr    = opcode == OPC_ARRAY_WIPE_A ||
		opcode == OPC_ARRAY_WIPE_B;
	wire         is_sec    = opcode == OPC_SMALL_WIPE;
	wire         frame_end = evt.cs_end && phase != PH_OP;
	wire         go_wsr    = frame_end && opcode == OPC_STATUS_WRITE &&
		edges == WSR_EDGES && wr_ok && !pin_guard; // see R3 see R5 see R6
	wire         go_sec    = frame_end && is_sec && edges == WIPE_EDGES &&
		wr_ok && !is_guarded(guard, sec_hi); // see R15 see R16 see R17 see R8
	wire         go_blk    = frame_end && is_blk && edges == WIPE_EDGES &&
		wr_ok && !is_guarded(guard, blk_hi); // see R18 see R19 see R8
	wire         go_arr    = frame_end && is_arr && edges == OP_EDGES &&
		wr_ok && guard == 2'h0; // see R20 see R21
	wire         go_wipe   = go_sec | go_blk | go_arr;
	wire         cycle_done = busy_flag && timer == 32'h0 && !wiping;
	logic [7:0]  status_word;
	wire  [7:0]  src_byte  = stat_rd ? status_word : mem[rd_addr];
	wire  [7:0]  cur_byte  = (ocnt == 3'h0) ? src_byte : obuf;

	always_comb begin
		status_word = 8'h00;
		status_word[BUSY_BIT]     = busy_flag; // see R22
		status_word[LATCH_BIT]    = write_latch;
		status_word[GUARD_LO_BIT] = region_guard_lo;
		status_word[GUARD_HI_BIT] = region_guard_hi;
		status_word[LOCK_BIT]     = status_lock_bit;
	end

	// instruction and address shifter, advanced on serial-clock rising edges
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			phase <= PH_HOLD;
			opcode <= 8'h00;
			shin <= 8'h00;
			addr_acc <= 24'h000000;
			edges <= 6'h00;
			cnt <= 5'h00;
			dual <= 1'b0;
			stat_rd <= 1'b0;
		end else if (evt.cs_start) begin
			phase <= PH_OP;
			edges <= 6'h00;
			cnt <= 5'h00;
			dual <= 1'b0;
			stat_rd <= 1'b0;
		end else if (evt.cs_active && evt.sclk_rise) begin
			if (edges != EDGE_MAX)
				edges <= edges + 6'h01;
			unique case (phase)
				PH_OP: begin
					shin <= op_next;
					cnt <= cnt_next;
					if (cnt_next == BYTE_BITS) begin
						opcode <= op_next;
						cnt <= 5'h00;
						unique case (op_next)
							OPC_READ, OPC_SMALL_WIPE, OPC_BLOCK_WIPE_A,
							OPC_BLOCK_WIPE_B:
								phase <= PH_ADDR;
							OPC_FAST_READ: // see R11
								phase <= busy_flag ? PH_HOLD : PH_ADDR;
							OPC_DUAL_READ: begin // see R13 see R12
								phase <= busy_flag ? PH_HOLD : PH_ADDR;
								dual <= ~busy_flag;
							end
							OPC_STATUS_READ: begin // see R14
								phase <= PH_DATA;
								stat_rd <= 1'b1;
							end
							OPC_STATUS_WRITE:
								phase <= PH_WSR;
							default:
								phase <= PH_HOLD;
						endcase
					end
				end
				PH_ADDR: begin
					addr_acc <= addr_next; // see R9
					cnt <= addr_done ? 5'h00 : cnt_next;
					if (addr_done) begin
						if (opcode == OPC_READ)
							phase <= PH_DATA;
						else if (opcode == OPC_FAST_READ || dual)
							phase <= PH_DUMMY;
						else
							phase <= PH_HOLD;
					end
				end
				PH_DUMMY: begin
					cnt <= cnt_next;
					if (cnt_next == DUMMY_BITS)
						phase <= PH_DATA;
				end
				PH_WSR: begin
					shin <= op_next;
					cnt <= cnt_next;
					if (cnt_next == BYTE_BITS)
						phase <= PH_HOLD;
				end
				PH_DATA, PH_HOLD: begin
				end
			endcase
		end
	end

	// output shifter, driven on serial-clock falling edges
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rd_addr <= '0;
			obuf <= 8'h00;
			ocnt <= 3'h0;
			dq0_out <= 1'b0;
			dq1_out <= 1'b0;
			dq0_oe <= 1'b0;
			dq1_oe <= 1'b0;
		end else if (!evt.cs_active) begin
			ocnt <= 3'h0;
			dq0_oe <= 1'b0;
			dq1_oe <= 1'b0;
		end else if (phase != PH_DATA) begin
			rd_addr <= addr_acc[ADDR_W-1:0];
		end else if (evt.sclk_fall) begin
			dq1_oe <= 1'b1;
			dq0_oe <= dual; // see R12 see R14
			ocnt <= ocnt + step[2:0];
			// address moves as each new byte is fetched; top wraps to zero
			if (ocnt == 3'h0 && !stat_rd)
				rd_addr <= rd_addr + addr_t'(1); // see R10
			if (dual) begin
				dq1_out <= cur_byte[7];
				dq0_out <= cur_byte[6];
				obuf <= {cur_byte[5:0], 2'b00};
			end else begin
				dq1_out <= cur_byte[7]; // see R9
				obuf <= {cur_byte[6:0], 1'b0};
			end
		end
	end

	// status bits and self-timed cycles
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			busy_flag <= 1'b0;
			write_latch <= 1'b0; // see R23
			region_guard_hi <= GUARD_RESET[1];
			region_guard_lo <= GUARD_RESET[0];
			status_lock_bit <= LOCK_RESET;
			timer <= 32'h0;
			wiping <= 1'b0;
			wipe_ptr <= '0;
			wipe_end <= '0;
		end else if (busy_flag) begin
			// frames during the cycle are ignored so the cycle runs untouched
			if (timer != 32'h0)
				timer <= timer - 32'h1;
			if (wiping) begin
				wiping <= wipe_ptr != wipe_end;
				wipe_ptr <= wipe_ptr + addr_t'(1);
			end
			if (cycle_done) begin
				busy_flag <= 1'b0; // see R4 see R16 see R18 see R20
				write_latch <= 1'b0; // see R23
			end
		end else if (frame_end && edges == OP_EDGES &&
			opcode == OPC_WRITE_UNLOCK) begin
			write_latch <= 1'b1; // see R1
		end else if (frame_end && edges == OP_EDGES &&
			opcode == OPC_WRITE_LOCK) begin
			write_latch <= 1'b0; // see R23
		end else if (go_wsr) begin
			busy_flag <= 1'b1; // see R4
			timer <= 32'(STATUS_WRITE_CYC - 1);
			status_lock_bit <= shin[LOCK_BIT]; // see R2
			region_guard_hi <= shin[GUARD_HI_BIT];
			region_guard_lo <= shin[GUARD_LO_BIT];
		end else if (go_wipe) begin
			busy_flag <= 1'b1;
			wiping <= 1'b1;
			timer <= go_sec ? 32'(SMALL_WIPE_CYC - 1)
				: go_blk ? 32'(BLOCK_WIPE_CYC - 1) : 32'(ARRAY_WIPE_CYC - 1);
			wipe_ptr <= go_sec ? sec_lo : go_blk ? blk_lo : '0;
			wipe_end <= go_sec ? sec_hi : go_blk ? blk_hi : '1;
		end
	end

	// array is not reset; only the erase walk writes it
	always_ff @(posedge clk) begin
		if (wiping)
			mem[wipe_ptr] <= 8'hFF; // see R15
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pin_guard_mode <= 1'b0;
			soft_guard_mode <= 1'b1;
		end else begin
			pin_guard_mode <= pin_guard; // see R7
			soft_guard_mode <= ~pin_guard; // see R6
		end
	end
endmodule // flash_core
`default_nettype wire

// ==== bench/flash_core_properties.sv ====
// port checker for the serial flash command logic
`default_nettype none
module flash_core_properties #(
	parameter int STATUS_WRITE_CYC = 20
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic cs_n,
	input wire logic wp_n,
	input wire logic dq0_oe,
	input wire logic dq1_oe,
	input wire logic busy_flag,
	input wire logic write_latch,
	input wire logic region_guard_hi,
	input wire logic region_guard_lo,
	input wire logic status_lock_bit,
	input wire logic pin_guard_mode,
	input wire logic soft_guard_mode
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	int busy_len;
	always_ff @(posedge clk or posedge sys_rst)
		if (sys_rst)
			busy_len <= 0;
		else
			busy_len <= busy_flag ? busy_len + 1 : 0;
	// eight cycles cover the pin synchroniser plus the mode register
	sequence s_locked_low;
		(status_lock_bit && !wp_n) [*8];
	endsequence
	sequence s_pin_high;
		wp_n [*8];
	endsequence
	chk_mode_inverse: assert property (soft_guard_mode != pin_guard_mode)
		else $error("guard modes overlap");
	chk_pin_enter: assert property (s_locked_low |=> pin_guard_mode)
		else $error("pin guard not entered");
	chk_pin_leave: assert property (s_pin_high |=> !pin_guard_mode)
		else $error("pin guard not left");
	chk_status_frozen: assert property (pin_guard_mode && $past(pin_guard_mode)
		|-> $stable({status_lock_bit, region_guard_hi, region_guard_lo}))
		else $error("status changed in pin guard");
	chk_busy_latch: assert property ($rose(busy_flag) |-> write_latch)
		else $error("cycle started without latch");
	chk_busy_frame_end: assert property ($rose(busy_flag) |-> $past(cs_n, 3))
		else $error("cycle started inside a frame");
	chk_busy_end: assert property ($fell(busy_flag) |-> $fell(write_latch))
		else $error("latch not cleared with busy");
	chk_busy_length: assert property ($fell(busy_flag)
		|-> busy_len >= STATUS_WRITE_CYC - 1)
		else $error("busy cycle too short");
	chk_latch_held: assert property (busy_flag && $past(busy_flag)
		|-> $stable(write_latch))
		else $error("latch moved while busy");
	chk_idle_release: assert property (cs_n [*8] |=> !dq0_oe && !dq1_oe)
		else $error("line driven while deselected");
	chk_dual_pair: assert property (dq0_oe |-> dq1_oe)
		else $error("line 0 driven alone");
	chk_busy_no_dual: assert property (busy_flag |-> !dq0_oe)
		else $error("dual output while busy");
endmodule // flash_core_properties
bind flash_core flash_core_properties #(
	.STATUS_WRITE_CYC(STATUS_WRITE_CYC)
) u_props (
	.clk(clk), .sys_rst(sys_rst), .cs_n(cs_n), .wp_n(wp_n),
	.dq0_oe(dq0_oe), .dq1_oe(dq1_oe), .busy_flag(busy_flag),
	.write_latch(write_latch), .region_guard_hi(region_guard_hi),
	.region_guard_lo(region_guard_lo), .status_lock_bit(status_lock_bit),
	.pin_guard_mode(pin_guard_mode), .soft_guard_mode(soft_guard_mode)
);
`default_nettype wire

// ==== bench/spi_host.sv ====
// host serial-bus controller model driving the flash pins
`default_nettype none
module spi_host (
	input  wire logic clk,
	input  wire logic l0,
	input  wire logic l1,
	input  wire logic oe0,
	input  wire logic oe1,
	output var  logic cs_n,
	output var  logic sclk,
	output var  logic h0,
	output var  logic h1
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		h0 = 1'b0;
		h1 = 1'b0;
	end
	// mode 0: data moves on the fall, the flash takes it on the rise
	task automatic step();
		sclk <= 1'b0;
		repeat (4) @(posedge clk);
		sclk <= 1'b1;
		repeat (4) @(posedge clk);
	endtask
	task automatic xfer(input logic [39:0] w, input int n, input int nrd,
		input bit dual, output logic [7:0] rb, output logic ok);
		logic [7:0] b;
		int k;
		rb = 8'hFF;
		ok = 1'b1;
		b = 8'h00;
		k = 39;
		@(posedge clk);
		cs_n <= 1'b0;
		repeat (4) @(posedge clk);
		for (int i = 0; i < n; i++) begin
			if (dual && i > 7) begin
				h1 <= w[k];
				h0 <= w[k-1];
				k -= 2;
			end else begin
				h0 <= w[k];
				k--;
			end
			step();
		end
		for (int j = 0; j < nrd * (dual ? 4 : 8); j++) begin
			// released lines toggle so a stale level never passes
			h0 <= ~h0;
			h1 <= ~h1;
			step();
			b = dual ? {b[5:0], l1, l0} : {b[6:0], l1};
			ok &= dual ? oe0 & oe1 : oe1;
			if (j % (dual ? 4 : 8) == (dual ? 3 : 7))
				rb &= b;
		end
		sclk <= 1'b0;
		repeat (4) @(posedge clk);
		cs_n <= 1'b1;
		h0 <= ~h0;
		repeat (10) @(posedge clk);
		// callers read the design's flops away from the edge that moves them
		@(negedge clk);
	endtask
endmodule // spi_host
`default_nettype wire

// ==== bench/tb.sv ====
// self-checking bench for the serial flash command logic
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import flash_pkg::*;
	logic       clk = 1'b0;
	logic       sys_rst = 1'b1;
	logic       wp_n = 1'b1;
	wire logic  cs_n, sclk, h0, h1, l0, l1, dq0_out, dq0_oe, dq1_out, dq1_oe;
	wire logic  busy_flag, write_latch, region_guard_hi, region_guard_lo;
	wire logic  status_lock_bit, pin_guard_mode, soft_guard_mode;
	wire logic [7:0] st = {status_lock_bit, 3'h0, region_guard_hi,
		region_guard_lo, write_latch, busy_flag};
	int         err_total = 0;
	int         samples_checked = 0;
	int         cyc = 0;
	logic [7:0] rb;
	logic       ok;
	logic [23:0] a;
	logic [7:0] wipe [5] = '{OPC_SMALL_WIPE, OPC_BLOCK_WIPE_A,
		OPC_BLOCK_WIPE_B, OPC_ARRAY_WIPE_A, OPC_ARRAY_WIPE_B};
	logic [7:0] rop [3] = '{OPC_READ, OPC_FAST_READ, OPC_DUAL_READ};
	int         ren [3] = '{32, 40, 24};
	always #20 clk = ~clk;
	assign l0 = dq0_oe ? dq0_out : h0;
	assign l1 = dq1_oe ? dq1_out : h1;
	spi_host u_host (.clk(clk), .l0(l0), .l1(l1), .oe0(dq0_oe), .oe1(dq1_oe),
		.cs_n(cs_n), .sclk(sclk), .h0(h0), .h1(h1));
	// short self-timed cycles and a 13-bit array keep the wipe walks brief
	flash_core #(.ADDR_W(13), .STATUS_WRITE_CYC(20), .SMALL_WIPE_CYC(20),
		.BLOCK_WIPE_CYC(20), .ARRAY_WIPE_CYC(20)) uut (
		.clk(clk), .sys_rst(sys_rst), .cs_n(cs_n), .sclk(sclk),
		.dq0_in(l0), .dq1_in(l1), .wp_n(wp_n), .dq0_out(dq0_out),
		.dq0_oe(dq0_oe), .dq1_out(dq1_out), .dq1_oe(dq1_oe),
		.busy_flag(busy_flag), .write_latch(write_latch),
		.region_guard_hi(region_guard_hi), .region_guard_lo(region_guard_lo),
		.status_lock_bit(status_lock_bit), .pin_guard_mode(pin_guard_mode),
		.soft_guard_mode(soft_guard_mode));
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
		end
	endtask
	function automatic logic [7:0] es(logic lk, logic [1:0] g, logic la,
		logic b);
		return {lk, 3'h0, g, la, b};
	endfunction
	task automatic end_of_test();
		$display("mismatches %0d checks %0d", err_total, samples_checked);
		if (err_total == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic cmd(input logic [39:0] w, input int n);
		u_host.xfer(w, n, 0, 1'b0, rb, ok);
	endtask
	task automatic unlock();
		cmd({OPC_WRITE_UNLOCK, 32'h0}, 8);
	endtask
	task automatic sr(input logic [7:0] v);
		cmd({OPC_STATUS_WRITE, v, 24'h0}, 16);
	endtask
	task automatic idle();
		while (busy_flag !== 1'b0)
			@(negedge clk);
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc > 100000) begin
			err_total++;
			end_of_test();
		end
	end
	initial begin
		void'($urandom(51112));
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (5) @(posedge clk);
		check(st, es(0, 0, 0, 0));
		sr(8'h8C);
		check(st, es(0, 0, 0, 0));
		unlock();
		cmd({OPC_STATUS_WRITE, 8'h8C, 24'h0}, 15);
		cmd({OPC_STATUS_WRITE, 8'h8C, 24'h0}, 17);
		check(st, es(0, 0, 1, 0));
		sr(($urandom & 8'h63) | 8'h04);
		check(st, es(0, 1, 1, 1));
		idle();
		check(st, es(0, 1, 0, 0));
		unlock();
		for (int i = 0; i < 5; i++) begin
			a = 24'h1800 | ($urandom & 24'h7FF);
			cmd({wipe[i], a, 8'h0}, i < 3 ? 32 : 8);
			check(st, es(0, 1, 1, 0));
		end
		@(posedge clk);
		wp_n <= 1'b0;
		sr(8'h80);
		idle();
		repeat (2) @(negedge clk);
		check({6'h0, pin_guard_mode, soft_guard_mode}, 8'h02);
		unlock();
		sr(8'h00);
		check(st, es(1, 0, 1, 0));
		@(posedge clk);
		wp_n <= 1'b1;
		repeat (12) @(negedge clk);
		check({6'h0, pin_guard_mode, soft_guard_mode}, 8'h01);
		sr(8'h00);
		idle();
		check(st, es(0, 0, 0, 0));
		unlock();
		cmd({OPC_SMALL_WIPE, 32'h0}, 31);
		check(st, es(0, 0, 1, 0));
		for (int i = 0; i < 3; i++) begin
			unlock();
			a = $urandom & 24'h1FFF;
			cmd({wipe[i * 2 - i / 2], a, 8'h0}, i < 2 ? 32 : 8);
			check(st, es(0, 0, 1, 1));
			if (i == 0) begin
				u_host.xfer({OPC_FAST_READ, a, 8'h0}, 40, 1, 1'b0, rb, ok);
				check({7'h0, ok}, 8'h00);
				u_host.xfer({OPC_DUAL_READ, a, 8'h0}, 24, 1, 1'b1, rb, ok);
				check({7'h0, ok}, 8'h00);
				sr(8'h0C);
			end
			idle();
			check(st, es(0, 0, 0, 0));
		end
		for (int i = 0; i < 3; i++) begin
			a = 24'h1FFE | ($urandom & 24'h1);
			u_host.xfer({rop[i], a, 8'h0}, ren[i], 3, i == 2, rb, ok);
			check(rb, 8'hFF);
			check({7'h0, ok}, 8'h01);
		end
		unlock();
		u_host.xfer({OPC_STATUS_READ, 32'h0}, 8, 2, 1'b0, rb, ok);
		check(rb, es(0, 0, 1, 0));
		end_of_test();
	end
endmodule // tb
`default_nettype wire
